// File: pkg/fetx_map.vh
// Constants for the fast Ethernet transmit/receive coding block
`ifndef FETX_MAP_VH
`define FETX_MAP_VH

// 4B/5B table, nibble 0 in the low five bits, nibble F in the top five
`define FETX_TBL {5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12, \
                  5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E}
`define FETX_TBL_W      80
`define FETX_CG_W       5

// Control code groups
`define FETX_CG_I       5'h1F
`define FETX_CG_J       5'h18
`define FETX_CG_K       5'h11
`define FETX_CG_T       5'h0D
`define FETX_CG_R       5'h07
`define FETX_CG_H       5'h04

// Nibble shown on the receive data lines for the start delimiter
`define FETX_NIB_SFD    4'h5

// Scrambler seed after reset and feedback taps for X[n-11], X[n-9]
`define FETX_SEED       11'h7FF
`define FETX_TAP_A      10
`define FETX_TAP_B      8

// Line levels, two bits per line bit
`define FETX_LVL_ZERO   2'h0
`define FETX_LVL_POS    2'h1
`define FETX_LVL_NEG    2'h2

// Matching idle bits needed before the descrambler counts as locked
`define FETX_LOCK_BITS  7'h3C
// Bits allowed after carrier for the start delimiter to complete
`define FETX_FC_BITS    4'hA
// Bit positions within a received group
`define FETX_GRP_LAST   3'h4
`define FETX_RXCLK_HI   3'h2

`endif

// File: rtl/fetx_rom.v
// 4B/5B encoder lookup memory with registered read data
`timescale 1ns/10ps
`include "fetx_map.vh"

module fetx_rom (
    input  wire       clk_i,
    input  wire [3:0] addr_i,
    output reg  [4:0] data_o
);

    localparam [`FETX_TBL_W-1:0] TBL = `FETX_TBL;

    // One code group per nibble, read one cycle after the address
    always @(posedge clk_i) begin
        data_o <= TBL[addr_i*`FETX_CG_W +: `FETX_CG_W];
    end

endmodule

// File: rtl/fetx_pcs.v
// Fast Ethernet coding sublayer: 4B/5B, scrambler, MLT-3, framing
// Notes on behaviour
// - While transmit enable is high each nibble is taken and encoded blindly.
// - Each data nibble maps to a fixed five-bit group; E, F give 11100, 11101.
// - Idle group 11111 is sent continuously between packets.
// - First preamble byte is replaced by J then K; later nibbles encode normally.
// - After enable drops, T then R are sent before idle resumes.
// - Coding error during data sends H group 00100 instead of the nibble.
// - Code stream is scrambled by an 11-bit LFSR, X[n]=X[n-11]^X[n-9].
// - Scrambled groups leave in parallel, one per two clocks, MSB as the first line bit.
// - MLT-3 holds level on 0, steps negative, zero, positive, zero on 1.
// - Transmit clocks, including the one to the MAC, come from the reference.
// - Receive descrambler locks its LFSR during idle, then removes the cipher.
// - Carrier rises once two non-adjacent zeros fall within ten bits.
// - Recognised J K raises receive valid; nibbles then follow the receive clock.
// - Carrier without J K is false carrier: drop carrier, raise receive error.
// - Nibbles pass until T, where valid drops; carrier drops one group after R.
// - Error on undefined group, idle before T R, or link loss in a frame.
// - Receive error rises at once and holds while the condition lasts.
// - In half duplex, collision shows while transmitting and receiving.
// - Bypass input skips both scrambler and descrambler.
`timescale 1ns/10ps
`include "fetx_map.vh"

module fetx_pcs (
    input  wire       mclk_i,
    input  wire       reset_n_i,
    input  wire       tx_en_i,
    input  wire [3:0] txd_i,
    input  wire       tx_coding_error_i,
    input  wire       scrambler_bypass_pin_i,
    input  wire       half_duplex_i,
    input  wire       link_ok_i,
    input  wire       rx_lclk_i,
    input  wire [1:0] rx_mlt_i,
    output reg        tx_clk_o,
    output reg  [4:0] tx_code_o,
    output reg  [9:0] tx_mlt_o,
    output reg        rx_clk_o,
    output reg  [3:0] rxd_o,
    output reg        rx_dv_o,
    output reg        rx_coding_error_o,
    output reg        crs_o,
    output reg        col_o
);

    localparam [`FETX_TBL_W-1:0] TBL = `FETX_TBL;

    // Transmit states, one-hot
    localparam [3:0] T_IDLE = 4'h1;
    localparam [3:0] T_K    = 4'h2;
    localparam [3:0] T_DATA = 4'h4;
    localparam [3:0] T_R    = 4'h8;
    // Receive states, one-hot
    localparam [5:0] R_IDLE  = 6'h01;
    localparam [5:0] R_SFD   = 6'h02;
    localparam [5:0] R_DATA  = 6'h04;
    localparam [5:0] R_END   = 6'h08;
    localparam [5:0] R_TAIL  = 6'h10;
    localparam [5:0] R_FALSE = 6'h20;

    // Scramble five bits MSB first; returns {next state, scrambled group}
    function [15:0] scr5;
        input [10:0] st;
        input [4:0]  cg;
        reg   [10:0] s;
        reg   [4:0]  o;
        reg          k;
        integer      i;
        begin
            s = st;
            o = cg;
            for (i = 4; i >= 0; i = i - 1) begin
                k    = s[`FETX_TAP_A] ^ s[`FETX_TAP_B];
                o[i] = cg[i] ^ k;
                s    = {s[9:0], k};
            end
            scr5 = {s, o};
        end
    endfunction

    // MLT-3 over five bits; returns {next step index, ten level bits}
    function [11:0] mlt5;
        input [1:0] idx;
        input [4:0] bits;
        reg   [1:0] n;
        reg   [9:0] lv;
        integer     i;
        begin
            n  = idx;
            lv = 10'h000;
            for (i = 4; i >= 0; i = i - 1) begin
                if (bits[i])
                    n = n + 2'h1;
                if (n[0])
                    lv[i*2 +: 2] = `FETX_LVL_ZERO;
                else if (n[1])
                    lv[i*2 +: 2] = `FETX_LVL_POS;
                else
                    lv[i*2 +: 2] = `FETX_LVL_NEG;
            end
            mlt5 = {n, lv};
        end
    endfunction

    // Two zeros, not adjacent, somewhere in a ten-bit window
    function carrier10;
        input [9:0] w;
        integer     i;
        integer     j;
        begin
            carrier10 = 1'b0;
            for (i = 0; i < 10; i = i + 1) begin
                for (j = i + 2; j < 10; j = j + 1) begin
                    if (!w[i] && !w[j])
                        carrier10 = 1'b1;
                end
            end
        end
    endfunction

    // Inverse table lookup; returns {valid, nibble}
    function [4:0] dec5;
        input [4:0] cg;
        integer     n;
        begin
            dec5 = 5'h00;
            for (n = 0; n < 16; n = n + 1) begin
                if (TBL[n*`FETX_CG_W +: `FETX_CG_W] == cg)
                    dec5 = {1'b1, n[3:0]};
            end
        end
    endfunction

    // Two-flop synchronisers for every pin input
    wire [11:0] pins_w = {tx_en_i, txd_i, tx_coding_error_i,
                          scrambler_bypass_pin_i, half_duplex_i, link_ok_i,
                          rx_lclk_i, rx_mlt_i};
    reg  [11:0] meta_q;
    reg  [11:0] sync_q;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_q <= 12'h000;
            sync_q <= 12'h000;
        end else begin
            meta_q <= pins_w;
            sync_q <= meta_q;
        end
    end
    wire       txen_s = sync_q[11];
    wire [3:0] txd_s  = sync_q[10:7];
    wire       txer_s = sync_q[6];
    wire       byp_s  = sync_q[5];
    wire       hd_s   = sync_q[4];
    wire       link_s = sync_q[3];
    wire       lclk_s = sync_q[2];
    wire [1:0] mlt_s  = sync_q[1:0];

    // ---------------- Transmit ----------------
    wire [4:0]  rom_q;
    reg         phase_q;
    reg         en_d1_q;
    reg         er_d1_q;
    reg  [3:0]  tx_st_q;
    reg  [3:0]  tx_st_d;
    reg  [4:0]  cg_d;
    reg  [10:0] tx_lfsr_q;
    reg  [1:0]  mlt_idx_q;
    wire [15:0] scr_w = scr5(tx_lfsr_q, cg_d);
    wire [4:0]  line_w = byp_s ? cg_d : scr_w[4:0];
    wire [11:0] mlt_w = mlt5(mlt_idx_q, line_w);

    fetx_rom u_rom (
        .clk_i  (mclk_i),
        .addr_i (txd_s),
        .data_o (rom_q)
    );

    // Group selection for the current transmit slot
    always @* begin
        tx_st_d = tx_st_q;
        cg_d    = `FETX_CG_I;
        case (tx_st_q)
            T_IDLE: begin
                if (en_d1_q) begin
                    cg_d    = `FETX_CG_J;
                    tx_st_d = T_K;
                end
            end
            T_K: begin
                cg_d    = `FETX_CG_K;
                tx_st_d = T_DATA;
            end
            T_DATA: begin
                if (!en_d1_q) begin
                    cg_d    = `FETX_CG_T;
                    tx_st_d = T_R;
                end else if (er_d1_q) begin
                    cg_d = `FETX_CG_H;
                end else begin
                    cg_d = rom_q;
                end
            end
            T_R: begin
                cg_d    = `FETX_CG_R;
                tx_st_d = T_IDLE;
            end
            default: begin
                tx_st_d = T_IDLE;
            end
        endcase
    end

    // Slot timing, scrambler and line output; one group per two cycles
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            phase_q   <= 1'b0;
            tx_clk_o  <= 1'b0;
            en_d1_q   <= 1'b0;
            er_d1_q   <= 1'b0;
            tx_st_q   <= T_IDLE;
            tx_lfsr_q <= `FETX_SEED;
            mlt_idx_q <= 2'h1; // Zero level, matching the reset line output
            tx_code_o <= `FETX_CG_I;
            tx_mlt_o  <= 10'h000;
        end else begin
            phase_q  <= ~phase_q;
            tx_clk_o <= ~phase_q;
            en_d1_q  <= txen_s;
            er_d1_q  <= txer_s;
            if (phase_q) begin
                tx_st_q   <= tx_st_d;
                tx_lfsr_q <= scr_w[15:5];
                tx_code_o <= line_w;
                mlt_idx_q <= mlt_w[11:10];
                tx_mlt_o  <= mlt_w[9:0];
            end
        end
    end

    // ---------------- Receive ----------------
    reg         lclk_prev_q;
    reg  [1:0]  mlt_prev_q;
    reg  [10:0] rx_lfsr_q;
    reg  [6:0]  lock_cnt_q;
    reg         locked_q;
    reg  [9:0]  win_q;
    reg  [5:0]  rx_st_q;
    reg  [2:0]  grp_cnt_q;
    reg  [3:0]  fc_cnt_q;
    wire        bit_stb  = lclk_s & ~lclk_prev_q;
    wire        nrz      = (mlt_s != mlt_prev_q);
    wire        key_pred = rx_lfsr_q[`FETX_TAP_A] ^ rx_lfsr_q[`FETX_TAP_B];
    wire        dbit     = byp_s ? nrz : (nrz ^ key_pred);
    wire [9:0]  win_n    = {win_q[8:0], dbit};
    wire [4:0]  grp      = win_n[4:0];
    wire [4:0]  dec_w    = dec5(grp);
    wire        grp_end  = (grp_cnt_q == `FETX_GRP_LAST);
    wire        in_frame = |(rx_st_q & (R_DATA | R_END | R_TAIL));

    // Line bit capture and descrambler lock
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lclk_prev_q <= 1'b0;
            mlt_prev_q  <= `FETX_LVL_ZERO;
            rx_lfsr_q   <= `FETX_SEED;
            lock_cnt_q  <= 7'h00;
            locked_q    <= 1'b0;
            win_q       <= 10'h3FF;
        end else begin
            lclk_prev_q <= lclk_s;
            if (!link_s) begin
                locked_q   <= 1'b0;
                lock_cnt_q <= 7'h00;
            end else if (bit_stb) begin
                mlt_prev_q <= mlt_s;
                win_q      <= win_n;
                if (byp_s) begin
                    locked_q <= 1'b1;
                end else if (!locked_q) begin
                    // Idle is all ones, so the key is the inverted line bit
                    rx_lfsr_q <= {rx_lfsr_q[9:0], ~nrz};
                    if (~nrz == key_pred)
                        lock_cnt_q <= lock_cnt_q + 7'h01;
                    else
                        lock_cnt_q <= 7'h00;
                    if (lock_cnt_q == `FETX_LOCK_BITS)
                        locked_q <= 1'b1;
                end else begin
                    rx_lfsr_q <= {rx_lfsr_q[9:0], key_pred};
                end
            end
        end
    end

    // Receive framing, decode and MII outputs
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_st_q           <= R_IDLE;
            grp_cnt_q         <= 3'h0;
            fc_cnt_q          <= 4'h0;
            rx_clk_o          <= 1'b0;
            rxd_o             <= 4'h0;
            rx_dv_o           <= 1'b0;
            rx_coding_error_o <= 1'b0;
            crs_o             <= 1'b0;
            col_o             <= 1'b0;
        end else begin
            col_o <= hd_s & ~tx_st_q[0] & crs_o;
            if (!link_s && in_frame) begin
                rx_coding_error_o <= 1'b1;
                rx_dv_o           <= 1'b0;
                crs_o             <= 1'b0;
                rx_st_q           <= R_FALSE;
            end else if (bit_stb) begin
                if (grp_end) begin
                    grp_cnt_q <= 3'h0;
                    rx_clk_o  <= 1'b0;
                end else begin
                    grp_cnt_q <= grp_cnt_q + 3'h1;
                    if (grp_cnt_q == `FETX_RXCLK_HI)
                        rx_clk_o <= 1'b1;
                end
                case (rx_st_q)
                    R_IDLE: begin
                        if (locked_q && carrier10(win_n)) begin
                            crs_o    <= 1'b1;
                            fc_cnt_q <= 4'h0;
                            rx_st_q  <= R_SFD;
                        end
                    end
                    R_SFD: begin
                        fc_cnt_q <= fc_cnt_q + 4'h1;
                        if (win_n == {`FETX_CG_J, `FETX_CG_K}) begin
                            rx_dv_o   <= 1'b1;
                            rxd_o     <= `FETX_NIB_SFD;
                            grp_cnt_q <= 3'h0;
                            rx_clk_o  <= 1'b0;
                            rx_st_q   <= R_DATA;
                        end else if (fc_cnt_q == `FETX_FC_BITS) begin
                            crs_o             <= 1'b0;
                            rx_coding_error_o <= 1'b1;
                            rx_st_q           <= R_FALSE;
                        end
                    end
                    R_DATA: begin
                        if (grp_end) begin
                            if (grp == `FETX_CG_T) begin
                                rx_dv_o           <= 1'b0;
                                rx_coding_error_o <= 1'b0;
                                rx_st_q           <= R_END;
                            end else if (grp == `FETX_CG_I) begin
                                rx_coding_error_o <= 1'b1;
                                rx_dv_o           <= 1'b0;
                                crs_o             <= 1'b0;
                                rx_st_q           <= R_FALSE;
                            end else if (dec_w[4]) begin
                                rxd_o             <= dec_w[3:0];
                                rx_coding_error_o <= 1'b0;
                            end else begin
                                rx_coding_error_o <= 1'b1;
                            end
                        end
                    end
                    R_END: begin
                        if (grp_end) begin
                            if (grp == `FETX_CG_R) begin
                                rx_st_q <= R_TAIL;
                            end else begin
                                rx_coding_error_o <= 1'b1;
                                crs_o             <= 1'b0;
                                rx_st_q           <= R_FALSE;
                            end
                        end
                    end
                    R_TAIL: begin
                        if (grp_end) begin
                            crs_o <= 1'b0;
                            if (grp == `FETX_CG_I) begin
                                rx_st_q <= R_IDLE;
                            end else begin
                                rx_coding_error_o <= 1'b1;
                                rx_st_q           <= R_FALSE;
                            end
                        end
                    end
                    R_FALSE: begin
                        // Error holds until a full window of idle returns
                        if (&win_n && link_s) begin
                            rx_coding_error_o <= 1'b0;
                            rx_st_q           <= R_IDLE;
                        end
                    end
                    default: begin
                        rx_st_q <= R_IDLE;
                    end
                endcase
            end
        end
    end

endmodule

// File: bench/fetx_pcs_sva.sv
// Port checker for the coding sublayer, bound to its top module
`timescale 1ns/10ps
`include "fetx_map.vh"
module fetx_pcs_sva (
    input wire       mclk_i,
    input wire       reset_n_i,
    input wire       tx_en_i,
    input wire [3:0] txd_i,
    input wire       tx_coding_error_i,
    input wire       scrambler_bypass_pin_i,
    input wire       half_duplex_i,
    input wire       link_ok_i,
    input wire       rx_lclk_i,
    input wire [1:0] rx_mlt_i,
    input wire       tx_clk_o,
    input wire [4:0] tx_code_o,
    input wire [9:0] tx_mlt_o,
    input wire       rx_clk_o,
    input wire [3:0] rxd_o,
    input wire       rx_dv_o,
    input wire       rx_coding_error_o,
    input wire       crs_o,
    input wire       col_o
);
    logic [1:0]  last_q;
    wire  [11:0] lv = {last_q, tx_mlt_o};
    wire  [4:0]  steps;
    wire  [4:0]  jump;
    genvar       g;

    // Line level that closed the previous group
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            last_q <= 2'h0;
        else
            last_q <= tx_mlt_o[1:0];
    end

    // Level change per bit, and direct swings between the outer levels
    for (g = 0; g < 5; g = g + 1) begin : gen_step
        assign steps[g] = lv[2*g+1 -: 2] != lv[2*g+3 -: 2];
        assign jump[g]  = steps[g] && lv[2*g+1 -: 2] != 2'h0
                          && lv[2*g+3 -: 2] != 2'h0;
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_slot;
        $fell(tx_clk_o);
    endsequence
    sequence s_quiet;
        (!tx_en_i && scrambler_bypass_pin_i)[*8];
    endsequence

    AST_GROUP_HOLD: assert property ($rose(tx_clk_o) |-> $stable(tx_code_o)
        && $stable(tx_mlt_o)) else $error("group changed mid slot");
    AST_MLT_STEP: assert property (s_slot |-> steps == tx_code_o)
        else $error("line level steps do not follow group bits");
    AST_MLT_ORDER: assert property (s_slot |-> jump == 5'h0)
        else $error("line level skipped zero");
    AST_IDLE_GAP: assert property (s_quiet ##1 (!tx_en_i
        && scrambler_bypass_pin_i)[*4] |-> tx_code_o == `FETX_CG_I)
        else $error("no idle group between frames");
    AST_DV_CRS: assert property (rx_dv_o |-> crs_o)
        else $error("valid without carrier");
    AST_RXD_CLK: assert property (!$fell(rx_clk_o) && !$rose(rx_dv_o)
        |-> $stable(rxd_o)) else $error("nibble off receive clock");
    AST_COL_CAUSE: assert property (col_o |-> $past(half_duplex_i, 3)
        && $past(crs_o)) else $error("collision without cause");
    AST_COL_RISE: assert property ((half_duplex_i && crs_o && tx_en_i)[*8]
        |-> col_o) else $error("collision not flagged");
    AST_LINK_ERR: assert property ($fell(link_ok_i) && rx_dv_o
        |-> ##[1:4] rx_coding_error_o) else $error("link loss unflagged");
    AST_ERR_HOLD: assert property (rx_coding_error_o && !link_ok_i
        |=> rx_coding_error_o) else $error("error dropped early");
    AST_RESET_QUIET: assert property ($rose(reset_n_i) |-> !rx_dv_o && !crs_o
        ##1 !rx_dv_o && !crs_o) else $error("receive busy after reset");
endmodule

bind fetx_pcs fetx_pcs_sva u_sva (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .tx_en_i(tx_en_i), .txd_i(txd_i), .tx_coding_error_i(tx_coding_error_i),
    .scrambler_bypass_pin_i(scrambler_bypass_pin_i),
    .half_duplex_i(half_duplex_i), .link_ok_i(link_ok_i),
    .rx_lclk_i(rx_lclk_i), .rx_mlt_i(rx_mlt_i), .tx_clk_o(tx_clk_o),
    .tx_code_o(tx_code_o), .tx_mlt_o(tx_mlt_o), .rx_clk_o(rx_clk_o),
    .rxd_o(rxd_o), .rx_dv_o(rx_dv_o), .rx_coding_error_o(rx_coding_error_o),
    .crs_o(crs_o), .col_o(col_o));

// File: bench/fetx_line_src.sv
// Link partner on the line: queued code groups sent scrambled as MLT-3
`timescale 1ns/10ps
module fetx_line_src (
    input  wire logic       bypass_i,
    output logic            lclk_o,
    output logic [1:0]      mlt_o
);
    logic [4:0]  q [$];
    logic [4:0]  grp;
    logic [10:0] h;
    logic [1:0]  ph;
    logic        b;
    integer      pos;

    // Queue one code group for the line
    task send(input logic [4:0] g);
        q.push_back(g);
    endtask

    // Bit clock runs with the idle stream, offset from the core clock
    initial begin
        lclk_o = 1'b0;
        mlt_o = 2'h0;
        h = 11'h5a5;
        ph = 2'h1;
        pos = 0;
        grp = 5'h1f;
        #7;
        forever #160 lclk_o = ~lclk_o;
    end

    // Next bit after each falling edge, settled for the rising edge
    always @(negedge lclk_o) begin
        if (pos == 0)
            grp = (q.size() != 0) ? q.pop_front() : 5'h1f;
        b = grp[4 - pos] ^ (!bypass_i & (h[10] ^ h[8]));
        h = {h[9:0], h[10] ^ h[8]};
        ph = b ? ph + 2'h1 : ph;
        mlt_o = (ph == 2'h0) ? 2'h2 : (ph == 2'h2) ? 2'h1 : 2'h0;
        pos = (pos == 4) ? 0 : pos + 1;
    end
endmodule

// File: bench/fetx_pcs_test.sv
// Self-checking bench for the fast Ethernet coding sublayer
`timescale 1ns/10ps
`include "fetx_map.vh"
module fetx_pcs_test;
    logic       mclk_i, reset_n_i, tx_en, tx_err, byp, hdx, link;
    logic [3:0] txd;
    wire        lclk, tx_clk, rx_clk, rx_dv, rx_err, crs, col;
    wire  [1:0] mlt;
    wire  [4:0] tx_code;
    wire  [9:0] tx_mlt;
    wire  [3:0] rxd;
    logic [4:0] cap [$];
    logic [3:0] rxq [$];
    logic       err_seen, dv_seen, col_seen;
    integer     fails, n_tests, cyc;
    logic [4:0] enc [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e,
        5'h0f, 5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

    fetx_line_src u_src (.bypass_i(byp), .lclk_o(lclk), .mlt_o(mlt));
    fetx_pcs u_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .tx_en_i(tx_en),
        .txd_i(txd), .tx_coding_error_i(tx_err), .scrambler_bypass_pin_i(byp),
        .half_duplex_i(hdx), .link_ok_i(link), .rx_lclk_i(lclk),
        .rx_mlt_i(mlt), .tx_clk_o(tx_clk), .tx_code_o(tx_code),
        .tx_mlt_o(tx_mlt), .rx_clk_o(rx_clk), .rxd_o(rxd), .rx_dv_o(rx_dv),
        .rx_coding_error_o(rx_err), .crs_o(crs), .col_o(col));

    always #20 mclk_i = ~mclk_i;

    // Record each group once its slot has settled, and nibbles while valid
    always @(negedge tx_clk) begin
        #1;
        cap.push_back(tx_code);
    end
    always @(posedge rx_clk) begin
        if (rx_dv === 1'b1)
            rxq.push_back(rxd);
    end

    // Sticky event flags and the hang limit
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (rx_err === 1'b1) err_seen = 1'b1;
        if (rx_dv === 1'b1) dv_seen = 1'b1;
        if (col === 1'b1) col_seen = 1'b1;
        if (cyc == 20000) begin
            fails = fails + 1;
            close_out();
        end
    end

    task automatic chk5(input string nm, input logic [4:0] e, g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            fails = fails + 1;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic chk4(input string nm, input logic [3:0] e, g);
        chk5(nm, {1'b0, e}, {1'b0, g});
    endtask
    task automatic chk1(input string nm, input logic e, g);
        chk5(nm, {4'h0, e}, {4'h0, g});
    endtask

    task close_out;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wait_rx(input integer n);
        for (int i = 0; i < 5000 && u_src.q.size() != 0; i++)
            @(posedge mclk_i);
        repeat (n) @(posedge mclk_i);
    endtask

    task automatic send_frame(input logic [4:0] g [$]);
        u_src.send(`FETX_CG_J);
        u_src.send(`FETX_CG_K);
        foreach (g[i]) u_src.send(g[i]);
    endtask

    task automatic t_tx_scram;
        logic k [$];
        logic any;
        byp <= 1'b0;
        repeat (4) @(posedge mclk_i);
        cap.delete();
        repeat (50) @(posedge mclk_i);
        any = 1'b0;
        for (int i = 0; i < 100; i++) k.push_back(~cap[i / 5][4 - i % 5]);
        for (int i = 11; i < 100; i++) chk1("key", k[i-11] ^ k[i-9], k[i]);
        foreach (k[i]) any = any | k[i];
        chk1("key active", 1'b1, any);
        $display("t_tx_scram done");
    endtask

    task automatic t_tx_frame;
        int j;
        byp <= 1'b1;
        hdx <= 1'b1;
        col_seen = 1'b0;
        send_frame('{5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0b, 5'h0b,
            `FETX_CG_T, `FETX_CG_R});
        for (int i = 0; i < 400 && crs !== 1'b1; i++) @(posedge mclk_i);
        cap.delete();
        for (int i = 0; i < 18; i++) begin
            tx_en <= 1'b1;
            txd <= (i < 2) ? 4'h5 : 4'(i - 2);
            tx_err <= (i == 11);
            repeat (2) @(posedge mclk_i);
        end
        tx_en <= 1'b0;
        tx_err <= 1'b0;
        repeat (16) @(posedge mclk_i);
        j = 0;
        while (j < cap.size() - 1 && cap[j] !== `FETX_CG_J) j++;
        chk5("lead idle", 5'h1f, cap[j-1]);
        chk5("second start", 5'h11, cap[j+1]);
        for (int i = 0; i < 16; i++) chk5("data", (i == 9) ? 5'h04 : enc[i], cap[j+2+i]);
        chk5("end first", 5'h0d, cap[j+18]);
        chk5("end second", 5'h07, cap[j+19]);
        chk5("trail idle", 5'h1f, cap[j+20]);
        chk1("collision", 1'b1, col_seen);
        wait_rx(160);
        hdx <= 1'b0;
        $display("t_tx_frame done");
    endtask

    task automatic t_rx_frame;
        logic [4:0] g [$];
        rxq.delete();
        err_seen = 1'b0;
        foreach (enc[i]) g.push_back(enc[i]);
        g.push_back(`FETX_CG_T);
        g.push_back(`FETX_CG_R);
        send_frame(g);
        wait_rx(160);
        chk1("frame length", 1'b1, rxq.size() == 17);
        chk4("delimiter nibble", 4'h5, rxq[0]);
        for (int i = 0; i < 16; i++) chk4("nibble", 4'(i), rxq[i+1]);
        chk1("carrier after end", 1'b0, crs);
        chk1("clean frame", 1'b0, err_seen);
        $display("t_rx_frame done");
    endtask

    task automatic t_rx_errors;
        err_seen = 1'b0;
        dv_seen = 1'b0;
        u_src.send(5'h15);
        wait_rx(160);
        chk1("false carrier err", 1'b1, err_seen);
        chk1("false carrier dv", 1'b0, dv_seen);
        chk1("false carrier crs", 1'b0, crs);
        err_seen = 1'b0;
        send_frame('{5'h0b, 5'h00, 5'h0b, `FETX_CG_T, `FETX_CG_R});
        wait_rx(160);
        chk1("bad group err", 1'b1, err_seen);
        chk1("err clears", 1'b0, rx_err);
        err_seen = 1'b0;
        send_frame('{5'h0b, 5'h1f, 5'h1f});
        wait_rx(160);
        chk1("idle mid frame", 1'b1, err_seen);
        chk1("dv after idle", 1'b0, rx_dv);
        $display("t_rx_errors done");
    endtask

    task automatic t_rx_link;
        repeat (800) @(posedge mclk_i);
        rxq.delete();
        send_frame('{enc[3], enc[12], `FETX_CG_T, `FETX_CG_R});
        wait_rx(160);
        chk4("scr delimiter", 4'h5, rxq[0]);
        chk4("scr nibble a", 4'h3, rxq[1]);
        chk4("scr nibble b", 4'hc, rxq[2]);
        send_frame('{enc[7], enc[7], enc[7], enc[7], enc[7], enc[7]});
        for (int i = 0; i < 400 && rx_dv !== 1'b1; i++) @(posedge mclk_i);
        repeat (40) @(posedge mclk_i);
        link <= 1'b0;
        repeat (300) @(posedge mclk_i);
        chk1("error while down", 1'b1, rx_err);
        chk1("carrier while down", 1'b0, crs);
        link <= 1'b1;
        repeat (900) @(posedge mclk_i);
        chk1("error after relock", 1'b0, rx_err);
        $display("t_rx_link done");
    endtask

    // Reset, then the scenarios in turn
    initial begin
        {mclk_i, reset_n_i, tx_en, tx_err, byp, hdx} = 6'h00;
        link = 1'b1;
        txd = 4'h0;
        {fails, n_tests, cyc} = 0;
        {err_seen, dv_seen, col_seen} = 3'h0;
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        t_tx_scram();
        t_rx_link();
        t_tx_frame();
        t_rx_frame();
        t_rx_errors();
        close_out();
    end
endmodule
